//--- rtl/pmr_bank.sv
// PHY management register bank on the 16-bit parallel register interface.
// Assumes one host access per cycle; PHY status levels arrive asynchronously.
// Behaviour
// - Writing one to reset bit pulses PHY reset
// - Control bit 14 loops host data back
// - Bit 13 forces speed; bits alias port control
// - Bit 5 picks crossover algorithm variant
// - Bit 4 forces straight or crossed mapping
// - Bit 3 disables automatic crossover detection
// - Bit 1 disables port transmitter
// - Bit 0 turns off port indicators
// - Status bit 2 shows link up
// - Status bit 5 shows negotiation complete
// - Capability bits are fixed constants
// - Two fixed identifier halves, read only
// - Advertisement bit 10 advertises pause
// - Bits 8,7 advertise 100 Mbps abilities
// - Bits 6,5 advertise 10 Mbps abilities
// - Offsets 0xDA to 0xE3 reserved
// - Indicator disable drives indicator pins high
`timescale 1ns/1ps
`include "pmr_defines.svh"

module pmr_bank
  import pmr_pkg::*;
#(
  parameter logic [15:0] ID_LOW = 16'h5A01, // Arbitrary identifier value
  parameter logic [15:0] ID_HIGH = 16'h00C3 // Arbitrary identifier value
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Host register interface
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [1:0] reg_be,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  // Port control register side of the aliases
  input wire logic pcr_wr,
  input wire logic [1:0] pcr_be,
  input wire logic [15:0] pcr_wdata,
  output logic [15:0] pcr_alias,
  // PHY status levels
  input wire logic link_up,
  input wire logic an_complete,
  // PHY controls
  output logic phy_rst,
  output pmr_ctrl_type ctrl,
  output pmr_adv_type adv,
  // Indicators
  input wire logic [3:0] led_in,
  output logic [3:0] led_out
);

  pmr_ctrl_type ctrl_r; // Shared control storage
  pmr_adv_type adv_r; // Shared advertisement storage
  logic phy_rst_r; // Reset pulse
  logic [15:0] rdata_r; // Read data
  logic rvalid_r; // Read answer strobe
  logic [3:0] led_r; // Indicator pins
  logic [1:0] link_sync_r; // Link synchroniser
  logic [1:0] anc_sync_r; // Negotiation done synchroniser
  logic [15:0] wm; // Host byte lane mask
  logic [15:0] pm; // Port control byte lane mask
  logic wr_rst; // Reset register write
  logic wr_bcr; // Basic control write
  logic wr_anar; // Advertisement write
  logic [15:0] rd_nxt; // Read mux

  // Lane masks and write decodes
  assign wm = {{8{reg_be[1]}}, {8{reg_be[0]}}};
  assign pm = {{8{pcr_be[1]}}, {8{pcr_be[0]}}};
  assign wr_rst = reg_wr && (reg_addr == `PMR_OFF_RST);
  assign wr_bcr = reg_wr && (reg_addr == `PMR_OFF_BCR);
  assign wr_anar = reg_wr && (reg_addr == `PMR_OFF_ANAR);

  // Self-clearing PHY block reset pulse
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      phy_rst_r <= 1'b0;
    end else begin
      phy_rst_r <= wr_rst && wm[0] && reg_wdata[0];
    end
  end

  // Control storage; host write wins over a same-cycle port control write
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_r <= `PMR_CTRL_RST;
    end else begin
      // Bank-only fields
      if (wr_bcr && wm[`PMR_BCR_LOOP]) begin
        ctrl_r.loopback <= reg_wdata[`PMR_BCR_LOOP];
      end
      if (wr_bcr && wm[`PMR_BCR_XVAR]) begin
        ctrl_r.crossover_variant_select <= reg_wdata[`PMR_BCR_XVAR];
      end
      // Aliased fields
      if (wr_bcr && wm[`PMR_BCR_F100]) begin
        ctrl_r.force_100 <= reg_wdata[`PMR_BCR_F100];
      end else if (pcr_wr && pm[`PMR_PCR_F100]) begin
        ctrl_r.force_100 <= pcr_wdata[`PMR_PCR_F100];
      end
      if (wr_bcr && wm[`PMR_BCR_ANEN]) begin
        ctrl_r.an_enable <= reg_wdata[`PMR_BCR_ANEN];
      end else if (pcr_wr && pm[`PMR_PCR_ANEN]) begin
        ctrl_r.an_enable <= pcr_wdata[`PMR_PCR_ANEN];
      end
      if (wr_bcr && wm[`PMR_BCR_RSTAN]) begin
        ctrl_r.restart_an <= reg_wdata[`PMR_BCR_RSTAN];
      end else if (pcr_wr && pm[`PMR_PCR_RSTAN]) begin
        ctrl_r.restart_an <= pcr_wdata[`PMR_PCR_RSTAN];
      end
      if (wr_bcr && wm[`PMR_BCR_FFULL]) begin
        ctrl_r.force_full <= reg_wdata[`PMR_BCR_FFULL];
      end else if (pcr_wr && pm[`PMR_PCR_FFULL]) begin
        ctrl_r.force_full <= pcr_wdata[`PMR_PCR_FFULL];
      end
      if (wr_bcr && wm[`PMR_BCR_STRT]) begin
        ctrl_r.force_straight <= reg_wdata[`PMR_BCR_STRT];
      end else if (pcr_wr && pm[`PMR_PCR_STRT]) begin
        ctrl_r.force_straight <= pcr_wdata[`PMR_PCR_STRT];
      end
      if (wr_bcr && wm[`PMR_BCR_XDIS]) begin
        ctrl_r.xover_disable <= reg_wdata[`PMR_BCR_XDIS];
      end else if (pcr_wr && pm[`PMR_PCR_XDIS]) begin
        ctrl_r.xover_disable <= pcr_wdata[`PMR_PCR_XDIS];
      end
      if (wr_bcr && wm[`PMR_BCR_TXDIS]) begin
        ctrl_r.tx_disable <= reg_wdata[`PMR_BCR_TXDIS];
      end else if (pcr_wr && pm[`PMR_PCR_TXDIS]) begin
        ctrl_r.tx_disable <= pcr_wdata[`PMR_PCR_TXDIS];
      end
      if (wr_bcr && wm[`PMR_BCR_LEDOFF]) begin
        ctrl_r.led_disable <= reg_wdata[`PMR_BCR_LEDOFF];
      end else if (pcr_wr && pm[`PMR_PCR_LEDOFF]) begin
        ctrl_r.led_disable <= pcr_wdata[`PMR_PCR_LEDOFF];
      end
    end
  end

  // Advertisement storage; selector stays constant
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      adv_r <= `PMR_ADV_RST;
    end else begin
      if (wr_anar && wm[`PMR_AN_PAUSE]) begin
        adv_r.pause <= reg_wdata[`PMR_AN_PAUSE];
      end else if (pcr_wr && pm[`PMR_PCR_PAUSE]) begin
        adv_r.pause <= pcr_wdata[`PMR_PCR_PAUSE];
      end
      if (wr_anar && wm[`PMR_AN_A100F]) begin
        adv_r.adv_100_full <= reg_wdata[`PMR_AN_A100F];
      end else if (pcr_wr && pm[`PMR_PCR_A100F]) begin
        adv_r.adv_100_full <= pcr_wdata[`PMR_PCR_A100F];
      end
      if (wr_anar && wm[`PMR_AN_A100H]) begin
        adv_r.adv_100_half <= reg_wdata[`PMR_AN_A100H];
      end else if (pcr_wr && pm[`PMR_PCR_A100H]) begin
        adv_r.adv_100_half <= pcr_wdata[`PMR_PCR_A100H];
      end
      if (wr_anar && wm[`PMR_AN_A10F]) begin
        adv_r.adv_10_full <= reg_wdata[`PMR_AN_A10F];
      end else if (pcr_wr && pm[`PMR_PCR_A10F]) begin
        adv_r.adv_10_full <= pcr_wdata[`PMR_PCR_A10F];
      end
      if (wr_anar && wm[`PMR_AN_A10H]) begin
        adv_r.adv_10_half <= reg_wdata[`PMR_AN_A10H];
      end else if (pcr_wr && pm[`PMR_PCR_A10H]) begin
        adv_r.adv_10_half <= pcr_wdata[`PMR_PCR_A10H];
      end
    end
  end

  // Status synchronisers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      link_sync_r <= 2'h0;
      anc_sync_r <= 2'h0;
    end else begin
      link_sync_r <= {link_sync_r[0], link_up};
      anc_sync_r <= {anc_sync_r[0], an_complete};
    end
  end

  // Read mux; read-only and reserved fields are fixed or zero
  always_comb begin
    rd_nxt = 16'h0000; // Unmapped, reserved and reset register read zero
    unique case (reg_addr)
      `PMR_OFF_BCR: begin
        rd_nxt = {1'b0, ctrl_r.loopback, ctrl_r.force_100, ctrl_r.an_enable, 2'h0,
                  ctrl_r.restart_an, ctrl_r.force_full, 2'h0, ctrl_r.crossover_variant_select,
                  ctrl_r.force_straight, ctrl_r.xover_disable, 1'b0, ctrl_r.tx_disable,
                  ctrl_r.led_disable};
      end
      `PMR_OFF_BSR: begin
        rd_nxt = `PMR_BSR_FIXED;
        rd_nxt[`PMR_BSR_AND] = anc_sync_r[1];
        rd_nxt[`PMR_BSR_LINK] = link_sync_r[1];
      end
      `PMR_OFF_IDL: begin
        rd_nxt = ID_LOW;
      end
      `PMR_OFF_IDH: begin
        rd_nxt = ID_HIGH;
      end
      `PMR_OFF_ANAR: begin
        rd_nxt = {5'h00, adv_r.pause, 1'b0, adv_r.adv_100_full, adv_r.adv_100_half,
                  adv_r.adv_10_full, adv_r.adv_10_half, `PMR_ANAR_SEL};
      end
      default: begin
        rd_nxt = 16'h0000;
      end
    endcase
  end

  // Registered read answer
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata_r <= 16'h0000;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= reg_rd;
      if (reg_rd) begin
        rdata_r <= rd_nxt;
      end
    end
  end

  // Indicator pins forced high when disabled
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      led_r <= 4'h0;
    end else begin
      led_r <= ctrl_r.led_disable ? 4'hF : led_in;
    end
  end

  // Outputs straight from flip-flops
  assign phy_rst = phy_rst_r;
  assign ctrl = ctrl_r;
  assign adv = adv_r;
  assign reg_rdata = rdata_r;
  assign reg_rvalid = rvalid_r;
  assign led_out = led_r;
  assign pcr_alias = {ctrl_r.led_disable, ctrl_r.tx_disable, ctrl_r.restart_an, 2'h0,
                      ctrl_r.xover_disable, ctrl_r.force_straight, 1'b0, ctrl_r.an_enable,
                      ctrl_r.force_100, ctrl_r.force_full, adv_r.pause, adv_r.adv_100_full,
                      adv_r.adv_100_half, adv_r.adv_10_full, adv_r.adv_10_half};

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // A second reset write right behind the first keeps the pulse high
  a_rst_pulse: assert property (wr_rst && reg_be[0] && reg_wdata[0]
    |=> phy_rst ##1 (!phy_rst || $past(wr_rst && reg_be[0] && reg_wdata[0])))
    else $error("reset pulse wrong");
  a_rst_reads0: assert property (reg_rd && reg_addr == `PMR_OFF_RST
    |=> reg_rdata == 16'h0000)
    else $error("reset register not zero");
  a_loop_write: assert property (wr_bcr && reg_be[1]
    |=> ctrl.loopback == $past(reg_wdata[14]))
    else $error("loopback not written");
  a_speed_alias: assert property (pcr_wr && pcr_be[0] && !wr_bcr
    |=> ctrl.force_100 == $past(pcr_wdata[6]) && pcr_alias[6] == ctrl.force_100)
    else $error("speed alias broken");
  a_anen_write: assert property (wr_bcr && reg_be[1]
    |=> ctrl.an_enable == $past(reg_wdata[12]) && pcr_alias[7] == $past(reg_wdata[12]))
    else $error("negotiation enable not written");
  a_duplex_alias: assert property (wr_bcr && reg_be[1]
    |=> pcr_alias[5] == $past(reg_wdata[8]))
    else $error("duplex alias broken");
  a_xvar_write: assert property (wr_bcr && reg_be[0]
    |=> ctrl.crossover_variant_select == $past(reg_wdata[5]))
    else $error("crossover variant not written");
  a_strt_alias: assert property (wr_bcr && reg_be[0]
    |=> ctrl.force_straight == $past(reg_wdata[4]) && pcr_alias[9] == $past(reg_wdata[4]))
    else $error("straight mapping not written");
  a_xdis_alias: assert property (wr_bcr && reg_be[0]
    |=> ctrl.xover_disable == $past(reg_wdata[3]) && pcr_alias[10] == $past(reg_wdata[3]))
    else $error("crossover disable not written");
  a_txdis_write: assert property (wr_bcr && reg_be[0]
    |=> ctrl.tx_disable == $past(reg_wdata[1]))
    else $error("transmit disable not written");
  a_led_high: assert property (ctrl.led_disable |=> led_out == 4'hF)
    else $error("indicators not high");
  a_link_read: assert property (reg_rd && reg_addr == `PMR_OFF_BSR
    |=> reg_rdata[2] == $past(link_sync_r[1], 1) && reg_rdata[13:12] == 2'h3)
    else $error("status read wrong");
  a_id_fixed: assert property (reg_rd && reg_addr == `PMR_OFF_IDL
    |=> reg_rdata == ID_LOW)
    else $error("identifier low wrong");
  a_pause_adv: assert property (wr_anar && reg_be[1]
    |=> adv.pause == $past(reg_wdata[10]) && pcr_alias[4] == $past(reg_wdata[10]))
    else $error("pause advertisement not written");
  a_adv10_write: assert property (wr_anar && reg_be[0]
    |=> pcr_alias[1:0] == $past(reg_wdata[6:5]))
    else $error("10 Mbps advertisement not written");
  a_sel_fixed: assert property (reg_rd && reg_addr == `PMR_OFF_ANAR
    |=> reg_rdata[4:0] == 5'h01)
    else $error("selector changed");
  a_reserved_zero: assert property (reg_rd && reg_addr == 8'hDC
    |=> reg_rdata == 16'h0000)
    else $error("reserved offset not zero");

  c_phy_reset: cover property (wr_rst && reg_wdata[0] ##1 phy_rst);
  c_adv_write: cover property (wr_anar ##1 !adv.pause);
  c_alias_write: cover property (pcr_wr ##1 reg_rd && reg_addr == `PMR_OFF_BCR);
  c_led_off: cover property (ctrl.led_disable ##1 led_out == 4'hF);
  c_link_seen: cover property (reg_rvalid && reg_rdata[2]);

endmodule // pmr_bank

//--- rtl/pmr_defines.svh
// Offsets, field positions, reset values and fixed read values of the PHY management bank.
// Included by the bank; defines only.
`ifndef PMR_DEFINES_SVH
`define PMR_DEFINES_SVH
// Byte offsets on the parallel register interface
`define PMR_OFF_RST 8'hD8
`define PMR_OFF_BCR 8'hE4
`define PMR_OFF_BSR 8'hE6
`define PMR_OFF_IDL 8'hE8
`define PMR_OFF_IDH 8'hEA
`define PMR_OFF_ANAR 8'hEC
// Basic control field positions
`define PMR_BCR_LOOP 14
`define PMR_BCR_F100 13
`define PMR_BCR_ANEN 12
`define PMR_BCR_RSTAN 9
`define PMR_BCR_FFULL 8
`define PMR_BCR_XVAR 5
`define PMR_BCR_STRT 4
`define PMR_BCR_XDIS 3
`define PMR_BCR_TXDIS 1
`define PMR_BCR_LEDOFF 0
// Port control alias positions
`define PMR_PCR_LEDOFF 15
`define PMR_PCR_TXDIS 14
`define PMR_PCR_RSTAN 13
`define PMR_PCR_XDIS 10
`define PMR_PCR_STRT 9
`define PMR_PCR_ANEN 7
`define PMR_PCR_F100 6
`define PMR_PCR_FFULL 5
`define PMR_PCR_PAUSE 4
`define PMR_PCR_A100F 3
`define PMR_PCR_A100H 2
`define PMR_PCR_A10F 1
`define PMR_PCR_A10H 0
// Advertisement field positions
`define PMR_AN_PAUSE 10
`define PMR_AN_A100F 8
`define PMR_AN_A100H 7
`define PMR_AN_A10F 6
`define PMR_AN_A10H 5
// Status field positions and fixed pattern (caps 13,12; bits 6,4)
`define PMR_BSR_AND 5
`define PMR_BSR_LINK 2
`define PMR_BSR_FIXED 16'h3050
`define PMR_ANAR_SEL 5'h01
// Reset values of the stored control and advertisement fields
`define PMR_CTRL_RST 10'h1B0
`define PMR_ADV_RST 5'h1F
`endif

//--- rtl/pmr_pkg.sv
// Types of the PHY management bank.
// No dependencies.
package pmr_pkg;
  // Stored basic control fields
  typedef struct packed {
    logic loopback;
    logic force_100;
    logic an_enable;
    logic restart_an;
    logic force_full;
    logic crossover_variant_select;
    logic force_straight;
    logic xover_disable;
    logic tx_disable;
    logic led_disable;
  } pmr_ctrl_type;
  // Stored advertisement fields
  typedef struct packed {
    logic pause;
    logic adv_100_full;
    logic adv_100_half;
    logic adv_10_full;
    logic adv_10_half;
  } pmr_adv_type;
endpackage

//--- verif/pmr_host_model.sv
// Host processor model on the parallel register interface of the PHY bank.
// Callers enter its tasks a fixed small delay after a rising edge of mclk.
`timescale 1ns/1ps

module pmr_host_model (
  // Clock
  input wire logic mclk,
  // Register interface driven by the host
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [1:0] reg_be,
  output logic [15:0] reg_wdata
);
  // Quiet bus at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_be = 2'h0;
    reg_wdata = 16'h0000;
  end

  // One access, held until the edge that takes it
  task automatic access(input logic w, input logic [7:0] a, input logic [1:0] be,
                        input logic [15:0] d);
    reg_addr = a;
    reg_wr = w;
    reg_rd = !w;
    reg_be = be;
    reg_wdata = d;
    @(posedge mclk);
  endtask

  // Release: strobes drop, stale address and data are inverted
  task automatic idle();
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~reg_addr;
    reg_wdata = ~reg_wdata;
  endtask
endmodule // pmr_host_model

//--- verif/tb.sv
// Self-checking bench of the PHY management bank with a host model.
// Reads are noted in a queue and compared when reg_rvalid appears.
`timescale 1ns/1ps

module tb;
  import pmr_pkg::*;
  localparam logic [15:0] ID_L = 16'h2B77; // Arbitrary identifier value
  localparam logic [15:0] ID_H = 16'h0E19; // Arbitrary identifier value
  // Design signals
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr;
  logic reg_wr, reg_rd;
  logic [1:0] reg_be;
  logic [15:0] reg_wdata, reg_rdata, pcr_alias;
  logic reg_rvalid, phy_rst;
  logic pcr_wr = 1'b0;
  logic [1:0] pcr_be = 2'h0;
  logic [15:0] pcr_wdata = 16'h0000;
  logic link_up = 1'b0;
  logic an_complete = 1'b0;
  logic [3:0] led_in = 4'h0;
  logic [3:0] led_out;
  pmr_ctrl_type ctrl;
  pmr_adv_type adv;
  // Bench state
  int fail_count = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [15:0] exp_q[$];
  logic [31:0] seed = 32'h4E6D;
  logic [15:0] bcr_m, anar_m, p;
  logic [31:0] r;
  logic [7:0] a;

  always #12.5 mclk = ~mclk;

  pmr_host_model host (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_be(reg_be), .reg_wdata(reg_wdata));

  pmr_bank #(.ID_LOW(ID_L), .ID_HIGH(ID_H)) uut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_be(reg_be), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .pcr_wr(pcr_wr), .pcr_be(pcr_be),
    .pcr_wdata(pcr_wdata), .pcr_alias(pcr_alias), .link_up(link_up),
    .an_complete(an_complete), .phy_rst(phy_rst), .ctrl(ctrl), .adv(adv), .led_in(led_in),
    .led_out(led_out));

  // Xorshift source
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Lane-masked update of the writable bits
  function automatic logic [15:0] upd(input logic [15:0] o, input logic [15:0] d,
                                      input logic [1:0] be, input logic [15:0] keep);
    logic [15:0] m;
    m = {{8{be[1]}}, {8{be[0]}}} & keep;
    return (o & ~m) | (d & m);
  endfunction

  // Port control view of the aliased bits
  function automatic logic [15:0] pcr_of(input logic [15:0] b, input logic [15:0] n);
    return {b[0], b[1], b[9], 2'b00, b[3], b[4], 1'b0, b[12], b[13], b[8], n[10], n[8:5]};
  endfunction

  task automatic chk(input string name, input logic [15:0] e, input logic [15:0] s);
    n_checks++;
    if (s !== e) begin
      $display("wrong value %s expected %h seen %h", name, e, s);
      fail_count++;
    end
  endtask

  task automatic final_report();
    // Reads whose answer never came count as mismatches
    if (exp_q.size() != 0) begin
      $display("wrong value pending reads expected 0 seen %0d", exp_q.size());
      fail_count++;
    end
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Host accesses; reads note their expected data
  task automatic wr(input logic [7:0] ad, input logic [1:0] be, input logic [15:0] d);
    #2;
    host.access(1'b1, ad, be, d);
  endtask

  task automatic rd(input logic [7:0] ad, input logic [15:0] e);
    exp_q.push_back(e);
    #2;
    pcr_wr = 1'b0;
    host.access(1'b0, ad, 2'b11, 16'h0000);
  endtask

  // Release the buses, then compare ctrl, adv, pcr_alias and led_out with the model
  task automatic check_state(input logic [3:0] li);
    #2;
    host.idle();
    pcr_wr = 1'b0;
    led_in = li;
    @(posedge mclk);
    #3;
    p = {6'h00, bcr_m[14:12], bcr_m[9:8], bcr_m[5:3], bcr_m[1:0]};
    chk("ctrl", p, {6'h00, ctrl});
    chk("adv", {11'h000, anar_m[10], anar_m[8:5]}, {11'h000, adv});
    chk("pcr_alias", pcr_of(bcr_m, anar_m), pcr_alias);
    chk("led_out", {12'h000, bcr_m[0] ? 4'hF : li}, {12'h000, led_out});
    @(posedge mclk);
  endtask

  // Reset pulse of n cycles, model back to reset values
  task automatic reset_dut(input int n);
    #2;
    rst = 1'b1;
    repeat (n) @(posedge mclk);
    #2;
    rst = 1'b0;
    bcr_m = 16'h3120;
    anar_m = 16'h05E1;
    @(posedge mclk);
  endtask

  // Monitor: oldest note against each read answer
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (reg_rvalid === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("read without request", 16'h0000, 16'hFFFF);
      end else begin
        chk("reg_rdata", exp_q.pop_front(), reg_rdata);
      end
    end
  end

  // Hang guard
  always @(posedge mclk) begin
    if (cycles == 5000) begin
      fail_count++;
      final_report();
    end
  end

  initial begin
    reset_dut(16);
    // Reset values of every register, back to back
    rd(8'hD8, 16'h0000);
    rd(8'hE4, 16'h3120);
    rd(8'hE6, 16'h3050);
    rd(8'hE8, ID_L);
    rd(8'hEA, ID_H);
    rd(8'hEC, 16'h05E1);
    check_state(4'h5);
    $display("test reset values done");
    // Reserved offsets ignore writes and read zero
    for (a = 8'hDA; a < 8'hE4; a = a + 8'h02) begin
      wr(a, 2'b11, 16'hFFFF);
      rd(a, 16'h0000);
    end
    check_state(4'hA);
    $display("test reserved done");
    // Block reset pulse, then self-cleared
    wr(8'hD8, 2'b01, 16'h0001);
    #2;
    host.idle();
    #1;
    chk("phy_rst", {15'h0000, phy_rst}, 16'h0001);
    @(posedge mclk);
    #3;
    chk("phy_rst", {15'h0000, phy_rst}, 16'h0000);
    @(posedge mclk);
    rd(8'hD8, 16'h0000);
    check_state(4'h3);
    $display("test block reset done");
    // Random writes through both alias views and to read-only places
    repeat (40) begin
      r = rnd();
      case (r[19:18])
        2'd0: begin
          wr(8'hE4, r[17:16], r[15:0]);
          bcr_m = upd(bcr_m, r[15:0], r[17:16], 16'h733B);
        end
        2'd1: begin
          wr(8'hEC, r[17:16], r[15:0]);
          anar_m = upd(anar_m, r[15:0], r[17:16], 16'h05E0);
        end
        2'd2: begin
          wr(r[20] ? 8'hE8 : 8'hE6, r[17:16], r[15:0]);
          rd(r[20] ? 8'hE8 : 8'hE6, r[20] ? ID_L : 16'h3050);
        end
        default: begin
          #2;
          pcr_wr = 1'b1;
          pcr_be = r[17:16];
          pcr_wdata = r[15:0];
          @(posedge mclk);
          p = upd(pcr_of(bcr_m, anar_m), r[15:0], r[17:16], 16'hE6FF);
          bcr_m = {1'b0, bcr_m[14], p[6], p[7], 2'b00, p[13], p[5], 2'b00, bcr_m[5], p[9],
                   p[10], 1'b0, p[14], p[15]};
          anar_m = {5'h00, p[4], 1'b0, p[3:0], 5'h01};
        end
      endcase
      rd(8'hE4, bcr_m);
      rd(8'hEC, anar_m);
      check_state(r[24:21]);
    end
    $display("test random writes done");
    // Link and negotiation status in all four combinations
    for (int k = 0; k < 4; k++) begin
      #2;
      host.idle();
      link_up = k[0];
      an_complete = k[1];
      repeat (4) @(posedge mclk);
      rd(8'hE6, 16'h3050 | {10'h000, k[1], 2'b00, k[0], 2'b00});
    end
    check_state(4'h6);
    $display("test status done");
    // Second reset in mid-run
    reset_dut(2);
    check_state(4'h9);
    $display("test second reset done");
    final_report();
  end
endmodule // tb
